// >>> nvsc_defs.vh
// Timing counts and constants for the store/recall port host controller
`ifndef NVSC_DEFS_VH
`define NVSC_DEFS_VH
`define NVSC_ADDR_W        15
`define NVSC_DATA_W        8
`define NVSC_CLK_NS        10
`define NVSC_ACC_NS        45
`define NVSC_ACC_CYC       ((`NVSC_ACC_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_STB_NS        30
`define NVSC_STB_CYC       ((`NVSC_STB_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_PUP_US        20
`define NVSC_PUP_CYC       ((`NVSC_PUP_US * 1000 + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CNT_W         16
`endif

// >>> nvsc_host.v
// Host controller driving the nonvolatile static memory over its pins
`timescale 1ns/1ps
`include "nvsc_defs.vh"
module nvsc_host #(
    parameter AW      = `NVSC_ADDR_W,
    parameter DW      = `NVSC_DATA_W,
    parameter CW      = `NVSC_CNT_W,
    parameter PUP_CYC = `NVSC_PUP_CYC
) (
    input  wire          clk,            // System clock
    input  wire          rst_n,          // Synchronous reset, active low
    input  wire          req_valid,      // Access request
    input  wire          req_write,      // 1 write, 0 read
    input  wire [AW-1:0] req_addr,       // Request address
    input  wire [DW-1:0] req_wdata,      // Write data
    input  wire          req_store,      // Request hardware store
    output reg           req_ready,      // Idle, request taken
    output reg           rsp_valid,      // Access done pulse
    output reg  [DW-1:0] rsp_rdata,      // Read data
    output reg           dev_busy,       // Device store or recall running
    output reg  [AW-1:0] byte_addr,      // Address pins
    output reg  [DW-1:0] byte_bus_o,     // Bus output value
    output reg           byte_bus_oe_n,  // Bus enable, low drives
    input  wire [DW-1:0] byte_bus_i,     // Bus sampled value
    output reg           sel_n,          // Chip select
    output reg           wr_n,           // Write strobe
    output reg           oe_n,           // Output enable
    output reg           store_busy_n_o, // Busy pin output value
    output reg           store_busy_oe_n,// Busy enable, low drives
    input  wire          store_busy_n_i  // Busy pin sampled level
);
    localparam S_PUP   = 3'd0;
    localparam S_IDLE  = 3'd1;
    localparam S_ACC   = 3'd2;
    localparam S_END   = 3'd3;
    localparam S_STB   = 3'd4;
    localparam S_WAITB = 3'd5;

    // Access and store pulse lengths cut to the counter width on purpose
    localparam [CW-1:0] ACC_CNT = `NVSC_ACC_CYC;
    localparam [CW-1:0] STB_CNT = `NVSC_STB_CYC;

    reg  [2:0]    state;
    reg           is_wr;
    reg           tload;
    reg  [CW-1:0] tcount;
    wire          tdone;

    nvsc_timer #(.W(CW)) u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (tload),
        .count (tcount),
        .done  (tdone)
    );

    always @(posedge clk) begin
        if (!rst_n) begin
            state           <= S_PUP;
            is_wr           <= 1'b0;
            tload           <= 1'b1;
            tcount          <= PUP_CYC[CW-1:0];
            req_ready       <= 1'b0;
            rsp_valid       <= 1'b0;
            rsp_rdata       <= {DW{1'b0}};
            dev_busy        <= 1'b1;
            byte_addr       <= {AW{1'b0}};
            byte_bus_o      <= {DW{1'b0}};
            byte_bus_oe_n   <= 1'b1;
            sel_n           <= 1'b1;
            wr_n            <= 1'b1;
            oe_n            <= 1'b1;
            store_busy_n_o  <= 1'b0;
            store_busy_oe_n <= 1'b1;
        end else begin
            tload     <= 1'b0;
            rsp_valid <= 1'b0;
            case (state)
            S_PUP: begin
                // Wait a fixed time after power-up, then wait in S_WAITB for the busy pin to rise
                if (tdone && !tload) begin
                    state <= S_WAITB;
                end
            end
            S_IDLE: begin
                dev_busy <= !store_busy_n_i;
                if (!store_busy_n_i) begin
                    req_ready <= 1'b0;
                    state     <= S_WAITB;
                end else if (req_store) begin
                    req_ready       <= 1'b0;
                    dev_busy        <= 1'b1;
                    store_busy_oe_n <= 1'b0;
                    tload           <= 1'b1;
                    tcount          <= STB_CNT;
                    state           <= S_STB;
                end else if (req_valid) begin
                    req_ready     <= 1'b0;
                    is_wr         <= req_write;
                    byte_addr     <= req_addr;
                    sel_n         <= 1'b0;
                    wr_n          <= !req_write;
                    oe_n          <= req_write;
                    byte_bus_o    <= req_wdata;
                    byte_bus_oe_n <= !req_write;
                    tload         <= 1'b1;
                    tcount        <= ACC_CNT;
                    state         <= S_ACC;
                end
            end
            S_ACC: begin
                if (tdone && !tload) begin
                    if (!is_wr) begin
                        rsp_rdata <= byte_bus_i;
                    end
                    sel_n <= 1'b1;
                    wr_n  <= 1'b1;
                    oe_n  <= 1'b1;
                    state <= S_END;
                end
            end
            S_END: begin
                // Hold data one cycle past the strobes for hold time
                byte_bus_oe_n <= 1'b1;
                rsp_valid     <= 1'b1;
                req_ready     <= 1'b1;
                state         <= S_IDLE;
            end
            S_STB: begin
                if (tdone && !tload) begin
                    store_busy_oe_n <= 1'b1;
                    state           <= S_WAITB;
                end
            end
            S_WAITB: begin
                // Pull-up may need a cycle to lift the released line
                if (store_busy_n_i && !store_busy_oe_n) begin
                    state <= S_WAITB;
                end else if (store_busy_n_i) begin
                    dev_busy  <= 1'b0;
                    req_ready <= 1'b1;
                    state     <= S_IDLE;
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule // nvsc_host

// >>> nvsc_host_chk.sv
// Pin-level assertions for the host controller
`timescale 1ns/1ps
module nvsc_host_chk (
    input wire        clk, rst_n, req_valid, req_ready, req_store, rsp_valid, dev_busy,
    input wire [14:0] byte_addr,
    input wire        byte_bus_oe_n, sel_n, wr_n, oe_n,
    input wire        store_busy_n_o, store_busy_oe_n, store_busy_n_i
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ADDR_HOLD: assert property (!sel_n && $past(!sel_n) |-> $stable(byte_addr))
        else $error("address moved");
    AST_BUS_TURN: assert property (!byte_bus_oe_n |-> oe_n)
        else $error("bus fight");
    AST_STROBE_SEL: assert property (!wr_n || !oe_n |-> !sel_n)
        else $error("strobe unselected");
    AST_RSP_LAT: assert property (req_valid && req_ready && !req_store && store_busy_n_i
        |-> ##9 rsp_valid) else $error("answer late");
    AST_STORE_PULL: assert property ($fell(store_busy_oe_n)
        |-> !store_busy_n_o && dev_busy ##[2:6] store_busy_oe_n) else $error("bad pull");
    AST_IDLE_WAIT: assert property ($fell(sel_n) |-> $past(store_busy_n_i))
        else $error("access while busy");
endmodule // nvsc_host_chk
bind nvsc_host nvsc_host_chk chk_u (.*);

// >>> nvsc_host_tb.sv
// Self-checking bench for the host controller
`timescale 1ns/1ps
module nvsc_host_tb;
    logic        clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_store = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0]  req_wdata = 8'h00;
    wire  [14:0] byte_addr;
    wire  [7:0]  rsp_rdata, byte_bus_o, byte_bus_i;
    wire         req_ready, rsp_valid, dev_busy, byte_bus_oe_n, sel_n, wr_n, oe_n;
    wire         store_busy_n_o, store_busy_oe_n, store_busy_n_i;
    int          num_errors = 0, checked = 0, cycles = 0;
    nvsc_host #(.PUP_CYC(20)) dut_u (.*);
    nvsc_mem mem_u (.*);
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (++cycles == 20000) begin num_errors++; tally_and_finish; end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task acc(input logic w, input logic [14:0] a, input logic [7:0] d);
        req_valid <= 1'b1; req_write <= w; req_addr <= a; req_wdata <= d;
        do @(posedge clk); while (req_ready !== 1'b1 || store_busy_n_i !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge clk); while (rsp_valid !== 1'b1);
        if (!w) chk(rsp_rdata, d);
    endtask
    task t_recall;
        chk({7'h0, dev_busy}, 8'h01);
        acc(1'b0, 15'h0012, 8'h12 ^ 8'h3C);
    endtask
    task t_rw;
        acc(1'b1, 15'h7FFF, 8'hA5);
        acc(1'b1, 15'h0000, 8'h5A);
        acc(1'b0, 15'h7FFF, 8'hA5);
        acc(1'b0, 15'h0000, 8'h5A);
    endtask
    task t_store;
        req_store <= 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_store <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h0, dev_busy}, 8'h01);
        do @(posedge clk); while (req_ready !== 1'b1);
        chk(mem_u.nv[15'h7FFF], 8'hA5);
        acc(1'b1, 15'h7FFF, 8'h0F);
        -> mem_u.pwr_fail;
        acc(1'b0, 15'h7FFF, 8'h0F);
        chk(mem_u.nv[15'h7FFF], 8'h0F);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_recall;
        t_rw;
        t_store;
        tally_and_finish;
    end
endmodule // nvsc_host_tb

// >>> nvsc_mem.sv
// Behavioural nonvolatile memory seen from its pins
`timescale 1ns/1ps
module nvsc_mem #(parameter STORE_NS = 200, RECALL_NS = 300) (
    input wire [14:0]  byte_addr,
    input wire [7:0]   byte_bus_o,
    input wire         byte_bus_oe_n, sel_n, wr_n, oe_n, store_busy_n_o, store_busy_oe_n,
    output logic [7:0] byte_bus_i,
    output wire        store_busy_n_i
);
    logic [7:0]  mem [0:32767], nv [0:32767];
    logic [14:0] lat;
    logic        busy_n = 1'b0;
    event        pwr_fail;
    // Pull-up unless someone pulls low
    assign store_busy_n_i = busy_n & (store_busy_oe_n | store_busy_n_o);
    // Released bus shows the inverse of the latched byte, never the last one
    always @* byte_bus_i = !byte_bus_oe_n ? byte_bus_o
        : (!sel_n && !oe_n) ? mem[lat] : ~mem[lat];
    always @(negedge sel_n) #1 lat = byte_addr;
    always @(negedge wr_n) @(posedge wr_n) mem[lat] = byte_bus_o;
    task automatic store_run;
        busy_n = 1'b0;
        #STORE_NS;
        foreach (mem[i]) nv[i] = mem[i];
        busy_n = 1'b1;
    endtask
    always @(negedge store_busy_n_i) if (busy_n) store_run();
    always @(pwr_fail) store_run();
    initial begin
        foreach (nv[i]) nv[i] = i[7:0] ^ 8'h3C;
        #RECALL_NS;
        foreach (mem[i]) mem[i] = nv[i];
        busy_n = 1'b1;
    end
endmodule // nvsc_mem

// >>> nvsc_timer.v
// Down-counter that flags when a loaded cycle count has elapsed
`timescale 1ns/1ps
module nvsc_timer #(
    parameter W = 16
) (
    input  wire         clk,   // System clock
    input  wire         rst_n, // Synchronous reset, active low
    input  wire         load,  // Load count
    input  wire [W-1:0] count, // Cycles to wait
    output reg          done   // High while idle or elapsed
);
    reg [W-1:0] left;
    always @(posedge clk) begin
        if (!rst_n) begin
            left <= {W{1'b0}};
            done <= 1'b1;
        end else if (load) begin
            left <= count;
            done <= 1'b0;
        end else if (left > 1) begin
            left <= left - 1'b1;
        end else begin
            left <= {W{1'b0}};
            done <= 1'b1;
        end
    end
endmodule // nvsc_timer
